// ==== cct_defs.svh ====
// Offsets, field positions, reset values and timing of the timer.
`ifndef CCT_DEFS_SVH
`define CCT_DEFS_SVH

`define CCT_OFS_COUNT 8'h40
`define CCT_OFS_CH0_VALUE 8'h4A
`define CCT_OFS_CH1_VALUE 8'h4C
`define CCT_OFS_CTRL 8'h50
`define CCT_OFS_EDGE 8'h51
`define CCT_OFS_CH0_OUT 8'h55
`define CCT_OFS_CH1_OUT 8'h56
`define CCT_OFS_STATUS 8'h58

`define CCT_CTRL_CLK_LSB 0
`define CCT_CTRL_RUN_BIT 3
`define CCT_CTRL_MODE0_BIT 4
`define CCT_EDGE_CH0_LSB 2
`define CCT_OUT_LEVEL_BIT 0
`define CCT_OUT_BUF_BIT 1

`define CCT_RST_COUNT 16'h0000
`define CCT_RST_VALUE 16'h0000
`define CCT_RST_CTRL 8'hC0
`define CCT_RST_EDGE 8'hC0
`define CCT_RST_OUT 8'hFC
`define CCT_CTRL_FIXED 8'hC0
`define CCT_EDGE_FIXED 8'hC0
`define CCT_OUT_FIXED 8'hFC

`define CCT_CLK_PERIOD_NS 100
`define CCT_MIN_PULSE_NS 100
`define CCT_MIN_PULSE_CYC \
   ((`CCT_MIN_PULSE_NS + `CCT_CLK_PERIOD_NS - 1) / `CCT_CLK_PERIOD_NS)

`endif

// ==== cct_pkg.sv ====
// Types shared by the capture/compare timer files.
package cct_pkg;
   typedef enum logic [1:0] {
      CCT_EDGE_OFF = 2'h0,
      CCT_EDGE_RISE = 2'h1,
      CCT_EDGE_FALL = 2'h2,
      CCT_EDGE_BOTH = 2'h3
   } cct_edge_t;
   typedef enum logic [1:0] {
      CCT_CNT_HALT = 2'h0,
      CCT_CNT_RUN = 2'h1
   } cct_cnt_state_t;
endpackage

// ==== cct_channel.sv ====
// One capture/compare channel: edge detection, value register, pin level.
`timescale 1ns/1ps
`include "cct_defs.svh"

module cct_channel
   import cct_pkg::*;
#(
   parameter int WIDTH = 16
) (
   input wire logic clk, // system clock
   input wire logic reset_n, // asynchronous reset, active low
   input wire logic pin_in, // channel pin, synchronous input
   input wire logic capture_mode, // 1 capture, 0 compare-out
   input wire logic [1:0] edge_sel, // valid capture edge
   input wire logic running, // counter in run state
   input wire logic tick, // count tick this cycle
   input wire logic [WIDTH-1:0] count, // current counter value
   input wire logic value_we, // software write of value
   input wire logic [WIDTH-1:0] value_wdata, // value write data
   input wire logic ctl_we, // software write of output control
   input wire logic [1:0] ctl_wdata, // buffer and level bits
   output logic [WIDTH-1:0] value, // capture/compare value
   output logic next_level_buffer, // level to take at next match
   output logic output_level, // level driving the pin
   output logic event_pulse // capture or match event
);

   // ************************************************************
   // Pin sampling
   // ************************************************************
   logic pin_q;
   logic pin_prev;
   logic rise;
   logic fall;
   logic edge_hit;
   logic match_hit;

   // Both stages rest at the pulled-up idle level, so no false edge
   // is seen when reset lets go.
   // [RULE18] pin sampled on clock
   always_ff @(negedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pin_q <= 1'b1;
      end else begin
         pin_q <= pin_in;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pin_prev <= 1'b1;
      end else begin
         pin_prev <= pin_q;
      end
   end

   assign rise = pin_q & ~pin_prev;
   assign fall = ~pin_q & pin_prev;

   // [RULE22] edge select decode
   always_comb begin
      case (cct_edge_t'(edge_sel))
         CCT_EDGE_RISE: edge_hit = rise;
         CCT_EDGE_FALL: edge_hit = fall;
         CCT_EDGE_BOTH: edge_hit = rise | fall;
         default: edge_hit = 1'b0;
      endcase
   end

   // A match is taken once per count value, on the tick that leaves it,
   // so a halted or slow counter does not fire repeatedly.
   // [RULE10] continuous compare
   assign match_hit = !capture_mode && running && tick && (count == value);

   // ************************************************************
   // Value register and levels
   // ************************************************************
   // [RULE9] value resets to zero
   // [RULE14] capture loads counter
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         value <= `CCT_RST_VALUE;
      end else if (capture_mode && running && edge_hit) begin
         value <= count;
      end else if (value_we) begin
         value <= value_wdata;
      end
   end

   // [RULE11] buffered next level
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         next_level_buffer <= 1'b0;
      end else if (ctl_we) begin
         next_level_buffer <= ctl_wdata[`CCT_OUT_BUF_BIT];
      end
   end

   // [RULE10] match copies buffer
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         output_level <= 1'b0;
      end else if (match_hit) begin
         output_level <= next_level_buffer;
      end else if (ctl_we) begin
         output_level <= ctl_wdata[`CCT_OUT_LEVEL_BIT];
      end
   end

   // [RULE20] shared event request
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         event_pulse <= 1'b0;
      end else begin
         event_pulse <= match_hit | (capture_mode && running && edge_hit);
      end
   end

endmodule

// ==== cct_timer.sv ====
// Two-channel capture/compare timer with 16-bit free-running counter.
`timescale 1ns/1ps
`include "cct_defs.svh"

// How it works
// [RULE1] 16-bit up-counter wraps, raises overflow request
// [RULE2] Counter readable, writable, resets to zero
// [RULE3] Counter writable any time, even counting
// [RULE4] Control bits 0-2 clock, bit 3 run
// [RULE5] Control bits 4,5 select channel capture mode
// [RULE6] Control upper two bits fixed one
// [RULE7] Control resets to C0: halted, compare-out
// [RULE8] Both channels identical, only addresses differ
// [RULE9] Channel value 16 bits, read/write, resets zero
// [RULE10] Compare match copies buffer bit to level
// [RULE11] Buffer bit holds level for next match
// [RULE12] Output control: two bits, resets FC
// [RULE13] Software avoids read-modify-write near match
// [RULE14] Valid edge captures counter, raises request
// [RULE15] Edge bits 2-3 channel 0, 4-5 channel 1
// [RULE16] Edge register upper ones, lower zeros fixed
// [RULE17] Edge register resets C0, capture disabled
// [RULE18] Capture pin sampled on falling clock edge
// [RULE19] Source holds pulses over one clock
// [RULE20] Match and capture share channel request
// [RULE21] Capture and compare only while running
// [RULE22] Edge code: off, rise, fall, both
// [RULE23] Counter advances one per selected tick
module cct_timer
   import cct_pkg::*;
#(
   parameter int WIDTH = 16,
   parameter int NCH = 2
) (
   input wire logic clk, // 10 MHz system clock
   input wire logic reset_n, // asynchronous reset, active low
   input wire logic timebase_tick, // time-base prescaler enable pulse
   input wire logic [7:0] addr, // register byte address
   input wire logic [15:0] wdata, // write data
   input wire logic wr, // write strobe
   input wire logic rd, // read strobe
   output logic [15:0] rdata, // read data, cycle after rd
   input wire logic [NCH-1:0] channel_pin_in, // channel pins as inputs
   output logic [NCH-1:0] channel_pin_out, // compare-out pin levels
   output logic [NCH-1:0] channel_pin_oe, // pin drive enables
   output logic overflow_irq, // counter overflow request pulse
   output logic [NCH-1:0] channel_irq // capture/match request pulse
);

   // ************************************************************
   // Registers
   // ************************************************************
   logic [WIDTH-1:0] free_run_count;
   logic [5:0] counter_control;
   logic [3:0] capture_edge_control;
   logic [2:0] div_cnt;
   logic tick;
   cct_cnt_state_t cnt_state;
   logic running;
   logic [WIDTH-1:0] next_count;
   logic wrap;
   logic [NCH-1:0] ch_value_we;
   logic [NCH-1:0] ch_ctl_we;
   logic [NCH-1:0] ch_mode;
   logic [NCH-1:0] ch_buf;
   logic [NCH-1:0] ch_level;
   logic [NCH-1:0] ch_event;
   logic [WIDTH-1:0] ch_value [NCH];
   logic [NCH-1:0] event_seen;
   logic overflow_seen;

   // ************************************************************
   // Count clock selection
   // ************************************************************
   // Codes 0..3 take the time-base tick divided by 1,2,4,8;
   // other codes select no clock at all and the counter stands.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         div_cnt <= 3'h0;
      end else if (timebase_tick) begin
         div_cnt <= div_cnt + 3'h1;
      end
   end

   // [RULE4] clock source select
   always_comb begin
      case (counter_control[`CCT_CTRL_CLK_LSB +: 3])
         3'h0: tick = timebase_tick;
         3'h1: tick = timebase_tick & div_cnt[0];
         3'h2: tick = timebase_tick & (&div_cnt[1:0]);
         3'h3: tick = timebase_tick & (&div_cnt[2:0]);
         default: tick = 1'b0;
      endcase
   end

   // [RULE4] run bit decode
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_state <= CCT_CNT_HALT;
      end else begin
         case (cnt_state)
            CCT_CNT_HALT:
               if (counter_control[`CCT_CTRL_RUN_BIT]) begin
                  cnt_state <= CCT_CNT_RUN;
               end
            CCT_CNT_RUN:
               if (!counter_control[`CCT_CTRL_RUN_BIT]) begin
                  cnt_state <= CCT_CNT_HALT;
               end
            default: cnt_state <= CCT_CNT_HALT;
         endcase
      end
   end

   // [RULE21] run state gates actions
   assign running = (cnt_state == CCT_CNT_RUN) &&
                    counter_control[`CCT_CTRL_RUN_BIT];

   // ************************************************************
   // Free-running counter
   // ************************************************************
   assign next_count = free_run_count + {{(WIDTH-1){1'b0}}, 1'b1};
   // [RULE1] overflow detect
   assign wrap = running && tick && (&free_run_count);

   // A software write wins over a tick in the same cycle.
   // [RULE3] write any time
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         // [RULE2] reset to zero
         free_run_count <= `CCT_RST_COUNT;
      end else if (wr && addr == `CCT_OFS_COUNT) begin
         free_run_count <= wdata[WIDTH-1:0];
      end else if (running && tick) begin
         // [RULE23] one step per tick; [RULE1] wraps to zero
         free_run_count <= next_count;
      end
   end

   // [RULE1] overflow request
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         overflow_irq <= 1'b0;
      end else begin
         overflow_irq <= wrap;
      end
   end

   // ************************************************************
   // Control registers
   // ************************************************************
   // [RULE7] control reset value
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         counter_control <= 6'(`CCT_RST_CTRL);
      end else if (wr && addr == `CCT_OFS_CTRL) begin
         counter_control <= wdata[5:0];
      end
   end

   // [RULE17] edge reset value
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         capture_edge_control <= 4'(`CCT_RST_EDGE >> 2);
      end else if (wr && addr == `CCT_OFS_EDGE) begin
         capture_edge_control <= wdata[5:2];
      end
   end

   // ************************************************************
   // Channels
   // ************************************************************
   // [RULE8] identical channels
   generate
      for (genvar i = 0; i < NCH; i++) begin : g_ch
         assign ch_value_we[i] = wr &&
            (addr == 8'(`CCT_OFS_CH0_VALUE + 2 * i));
         assign ch_ctl_we[i] = wr &&
            (addr == 8'(`CCT_OFS_CH0_OUT + i));
         // [RULE5] mode bit per channel
         assign ch_mode[i] = counter_control[`CCT_CTRL_MODE0_BIT + i];

         // [RULE15] edge field per channel
         cct_channel #(
            .WIDTH(WIDTH)
         ) u_ch (
            .clk(clk),
            .reset_n(reset_n),
            .pin_in(channel_pin_in[i]),
            .capture_mode(ch_mode[i]),
            .edge_sel(capture_edge_control[2*i +: 2]),
            .running(running),
            .tick(tick),
            .count(free_run_count),
            .value_we(ch_value_we[i]),
            .value_wdata(wdata[WIDTH-1:0]),
            .ctl_we(ch_ctl_we[i]),
            .ctl_wdata(wdata[1:0]),
            .value(ch_value[i]),
            .next_level_buffer(ch_buf[i]),
            .output_level(ch_level[i]),
            .event_pulse(ch_event[i])
         );

         always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
               channel_pin_out[i] <= 1'b0;
               channel_pin_oe[i] <= 1'b0;
               channel_irq[i] <= 1'b0;
            end else begin
               channel_pin_out[i] <= ch_level[i];
               channel_pin_oe[i] <= ~ch_mode[i];
               channel_irq[i] <= ch_event[i];
            end
         end

         // Sticky copy for polling; set wins over the read that clears it.
         always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
               event_seen[i] <= 1'b0;
            end else if (ch_event[i]) begin
               event_seen[i] <= 1'b1;
            end else if (rd && addr == `CCT_OFS_STATUS) begin
               event_seen[i] <= 1'b0;
            end
         end
      end
   endgenerate

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         overflow_seen <= 1'b0;
      end else if (overflow_irq) begin
         overflow_seen <= 1'b1;
      end else if (rd && addr == `CCT_OFS_STATUS) begin
         overflow_seen <= 1'b0;
      end
   end

   // ************************************************************
   // Read path
   // ************************************************************
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rdata <= 16'h0000;
      end else if (rd) begin
         case (addr)
            `CCT_OFS_COUNT: rdata <= free_run_count;
            `CCT_OFS_CH0_VALUE: rdata <= ch_value[0];
            `CCT_OFS_CH1_VALUE: rdata <= ch_value[1];
            // [RULE6] upper bits read one
            `CCT_OFS_CTRL:
               rdata <= {8'h00, `CCT_CTRL_FIXED | {2'b00, counter_control}};
            // [RULE16] fixed edge bits
            `CCT_OFS_EDGE:
               rdata <= {8'h00, `CCT_EDGE_FIXED |
                         {2'b00, capture_edge_control, 2'b00}};
            // [RULE12] two live bits
            `CCT_OFS_CH0_OUT:
               rdata <= {8'h00, `CCT_OUT_FIXED |
                         {6'h00, ch_buf[0], ch_level[0]}};
            `CCT_OFS_CH1_OUT:
               rdata <= {8'h00, `CCT_OUT_FIXED |
                         {6'h00, ch_buf[1], ch_level[1]}};
            `CCT_OFS_STATUS:
               rdata <= {13'h0000, event_seen, overflow_seen};
            default: rdata <= 16'h0000;
         endcase
      end else begin
         rdata <= 16'h0000;
      end
   end

endmodule

// ==== cct_timer_props.sv ====
// Port-level assertion checker for the capture/compare timer.
`timescale 1ns/1ps
module cct_timer_props
   import cct_pkg::*;
#(
   parameter int WIDTH = 16,
   parameter int NCH = 2
) (
   input wire logic clk, // system clock
   input wire logic reset_n, // reset, active low
   input wire logic timebase_tick, // count tick
   input wire logic [7:0] addr, // register address
   input wire logic [15:0] wdata, // write data
   input wire logic wr, // write strobe
   input wire logic rd, // read strobe
   input wire logic [15:0] rdata, // read data
   input wire logic [NCH-1:0] channel_pin_in, // pin levels in
   input wire logic [NCH-1:0] channel_pin_out, // pin levels out
   input wire logic [NCH-1:0] channel_pin_oe, // pin drive enables
   input wire logic overflow_irq, // overflow pulse
   input wire logic [NCH-1:0] channel_irq // channel event pulses
);
   logic run_q;
   logic [1:0] mode_q;
   logic [2:0] halt_cnt;
   logic out0_wr;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   assign out0_wr = wr && addr == 8'h55;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         run_q <= 1'b0;
         mode_q <= 2'b00;
      end else if (wr && addr == 8'h50) begin
         run_q <= wdata[3];
         mode_q <= wdata[5:4];
      end
   end
   // Events already in flight when the run bit drops need a few cycles.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         halt_cnt <= 3'h0;
      end else if (run_q) begin
         halt_cnt <= 3'h0;
      end else if (halt_cnt != 3'h4) begin
         halt_cnt <= halt_cnt + 3'h1;
      end
   end
   sequence s_read(a);
      rd && addr == a;
   endsequence
   sequence s_ctrl_write;
      wr && addr == 8'h50 ##1 !(wr && addr == 8'h50);
   endsequence
   a_ovf_single_pulse: assert property (
      overflow_irq |=> !overflow_irq) else $error("overflow pulse too long");
   a_oe_follows_mode: assert property (
      s_ctrl_write |=> channel_pin_oe == ~mode_q)
      else $error("pin enable disagrees with mode");
   a_ctrl_fixed_ones: assert property (
      s_read(8'h50) |=> rdata[7:6] == 2'b11) else $error("ctrl top bits");
   a_edge_fixed_bits: assert property (
      s_read(8'h51) |=> rdata[7:6] == 2'b11 && rdata[1:0] == 2'b00)
      else $error("edge fixed bits");
   a_out_fixed_ones: assert property (
      rd && (addr == 8'h55 || addr == 8'h56) |=> rdata[7:2] == 6'h3F)
      else $error("output control top bits");
   a_halt_stays_quiet: assert property (
      halt_cnt == 3'h4 |-> channel_irq == '0 && !overflow_irq)
      else $error("event while halted");
   a_pin_change_cause: assert property (
      $changed(channel_pin_out[0]) |-> channel_irq[0] || $past(out0_wr, 2))
      else $error("pin level changed without cause");
   a_rdata_only_after: assert property (
      !rd |=> rdata == 16'h0000) else $error("read data without read");
endmodule
bind cct_timer cct_timer_props #(.WIDTH(WIDTH), .NCH(NCH)) u_props (
   .clk(clk), .reset_n(reset_n), .timebase_tick(timebase_tick),
   .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
   .channel_pin_in(channel_pin_in), .channel_pin_out(channel_pin_out),
   .channel_pin_oe(channel_pin_oe), .overflow_irq(overflow_irq),
   .channel_irq(channel_irq));

// ==== cct_pin_source.sv ====
// Pulse source standing on the two channel pins.
`timescale 1ns/1ps
module cct_pin_source (
   input wire logic clk, // system clock
   output logic [1:0] pin_drive // level offered to each pin
);
   // The capture inputs carry pull-ups, so an idle pin rests high.
   initial pin_drive = 2'b11;
   task automatic pulse(input int ch, input int cycles);
      @(posedge clk);
      pin_drive[ch] <= 1'b0;
      repeat (cycles) @(posedge clk);
      pin_drive[ch] <= 1'b1;
      repeat (4) @(posedge clk);
   endtask
endmodule

// ==== cct_timer_bench.sv ====
// Self-checking bench for the capture/compare timer.
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; \
   if ((g) !== (e)) begin err_count++; \
   $display("ERROR %s expected %h seen %h", n, e, g); end end
module cct_timer_bench;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic tick = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [15:0] wdata = 16'h0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [15:0] rdata;
   logic [1:0] pin_out, pin_oe, pin_drive, pin_lvl, irq;
   logic ovf;
   int err_count = 0;
   int total_checks = 0;
   int irq_n [2];
   int ovf_n;
   int exp_n [4] = '{0, 1, 1, 2};
   always #50 clk = ~clk;
   // A driven pin shows the timer's level, a released one the source's.
   assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & pin_drive);
   cct_timer dut (.clk(clk), .reset_n(reset_n), .timebase_tick(tick),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .channel_pin_in(pin_lvl), .channel_pin_out(pin_out),
      .channel_pin_oe(pin_oe), .overflow_irq(ovf), .channel_irq(irq));
   cct_pin_source src (.clk(clk), .pin_drive(pin_drive));
   always @(posedge clk) begin
      if (irq[0] === 1'b1) irq_n[0]++;
      if (irq[1] === 1'b1) irq_n[1]++;
      if (ovf === 1'b1) ovf_n++;
   end
   task automatic wreg(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [15:0] e,
         input string n);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      `CHK(n, e, rdata)
   endtask
   // The run state lags the run bit by a cycle, so settle before ticking.
   task automatic run(input logic [15:0] c);
      wreg(8'h50, c);
      repeat (2) @(posedge clk);
   endtask
   task automatic tk(input int n);
      repeat (n) begin
         @(posedge clk) tick <= 1'b1;
         @(posedge clk) tick <= 1'b0;
      end
      // Three edges let a request pulse be counted before any check.
      repeat (3) @(posedge clk);
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset;
      rchk(8'h40, 16'h0000, "count");
      rchk(8'h4A, 16'h0000, "value0");
      rchk(8'h4C, 16'h0000, "value1");
      rchk(8'h50, 16'h00C0, "ctrl");
      rchk(8'h51, 16'h00C0, "edge");
      rchk(8'h55, 16'h00FC, "out0");
      rchk(8'h56, 16'h00FC, "out1");
      `CHK("pin_oe", 2'b11, pin_oe)
      $display("t_reset done");
   endtask
   task automatic t_fixed;
      wreg(8'h50, 16'h0000);
      rchk(8'h50, 16'h00C0, "ctrl");
      wreg(8'h51, 16'h00FF);
      rchk(8'h51, 16'h00FC, "edge");
      wreg(8'h55, 16'h0000);
      rchk(8'h55, 16'h00FC, "out0");
      wreg(8'h56, 16'h0003);
      rchk(8'h56, 16'h00FF, "out1");
      wreg(8'h60, 16'hFFFF);
      rchk(8'h60, 16'h0000, "unmapped");
      wreg(8'h51, 16'h00C0);
      $display("t_fixed done");
   endtask
   task automatic t_count;
      wreg(8'h40, 16'h1234);
      run(16'h0008);
      rchk(8'h40, 16'h1234, "count");
      tk(3);
      rchk(8'h40, 16'h1237, "count");
      ovf_n = 0;
      wreg(8'h40, 16'hFFFF);
      tk(1);
      `CHK("ovf_n", 1, ovf_n)
      rchk(8'h40, 16'h0000, "count");
      run(16'h0000);
      tk(2);
      rchk(8'h40, 16'h0000, "count");
      // Divided sources step a fixed share of ticks whatever the phase.
      run(16'h0009);
      tk(4);
      rchk(8'h40, 16'h0002, "count_div2");
      run(16'h000B);
      tk(8);
      rchk(8'h40, 16'h0003, "count_div8");
      run(16'h000D);
      tk(2);
      rchk(8'h40, 16'h0003, "count_none");
      $display("t_count done");
   endtask
   task automatic t_compare;
      // levels written long before any match
      wreg(8'h40, 16'h000E);
      wreg(8'h4A, 16'h0010);
      wreg(8'h4C, 16'h0011);
      wreg(8'h55, 16'h0002);
      wreg(8'h56, 16'h0001);
      run(16'h0008);
      irq_n = '{0, 0};
      tk(2);
      `CHK("pin_out", 2'b10, pin_out)
      tk(2);
      `CHK("irq0_n", 1, irq_n[0])
      `CHK("irq1_n", 1, irq_n[1])
      `CHK("pin_out", 2'b01, pin_out)
      rchk(8'h55, 16'h00FF, "out0");
      rchk(8'h56, 16'h00FC, "out1");
      rchk(8'h58, 16'h0007, "status");
      rchk(8'h58, 16'h0000, "status_clr");
      $display("t_compare done");
   endtask
   task automatic t_capture;
      run(16'h0038);
      `CHK("pin_oe", 2'b00, pin_oe)
      for (int c = 0; c < 4; c++) begin
         wreg(8'h51, 16'(c) << 2);
         wreg(8'h40, 16'h0100 + 16'(c));
         irq_n[0] = 0;
         src.pulse(0, 3);
         `CHK("cap0_n", exp_n[c], irq_n[0])
         rchk(8'h4A, c == 0 ? 16'h0010 : 16'h0100 + 16'(c), "v0");
      end
      wreg(8'h51, 16'h0020);
      wreg(8'h40, 16'h0200);
      irq_n[1] = 0;
      src.pulse(1, 3);
      `CHK("cap1_n", 1, irq_n[1])
      rchk(8'h4C, 16'h0200, "value1");
      run(16'h0030);
      wreg(8'h51, 16'h003C);
      irq_n = '{0, 0};
      src.pulse(0, 3);
      src.pulse(1, 3);
      `CHK("halt_n", 0, irq_n[0] + irq_n[1])
      rchk(8'h4A, 16'h0103, "value0");
      $display("t_capture done");
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      t_reset;
      t_fixed;
      t_count;
      t_compare;
      t_capture;
      complete_run;
   end
   // The scenarios need well under a thousand cycles.
   initial begin
      #1000000;
      err_count++;
      complete_run;
   end
endmodule
